// [bench/window_watchdog_timer_test.sv]
`timescale 1ns/1ns
module window_watchdog_timer_test;
   import wwd_pkg::*;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic kick_req = 1'b0;
   logic kick, out_n, oe, fault;
   wwd_strap_t straps = wwd_strap_t'(6'h00);
   wwd_req_t reg_req = '0;
   logic [DATA_W-1:0] rdata;
   int failures = 0;
   int compares = 0;
   int n;
   wwd_pin_t tps[3] = '{PIN_OPEN, PIN_PULLUP, PIN_CAP};
   wwd_pin_t dps[3] = '{PIN_PULLUP, PIN_CAP, PIN_PULLUP};
   int ups[3] = '{400, 800, 200};
   int hds[3] = '{10, 12, 10};
   // Pull-up on the open-drain fault wire
   assign fault = oe ? 1'b0 : 1'b1;
   initial forever #2 core_clk = ~core_clk;
   wwd_kicker i_wwd_kicker (.core_clk(core_clk), .rst(rst), .kick_req(kick_req),
      .watchdog_kick_in(kick));
   wwd_top #(.UPPER_OPEN_TIME_US(200), .UPPER_PULLUP_TIME_US(400), .HOLD_OPEN_TIME_US(10),
      .HOLD_PULLUP_TIME_US(5), .TICK_DIV(2)) i_wwd_top (.core_clk(core_clk), .rst(rst),
      .watchdog_kick_in(kick), .straps(straps), .watchdog_fault_in(fault),
      .watchdog_fault_out_n(out_n), .watchdog_fault_oe(oe), .reg_req(reg_req),
      .reg_rdata(rdata));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic near(input int v, input int e);
      chk(32'(v >= e - 6 && v <= e + 6), 32'h0000_0001);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_req.addr <= a;
      reg_req.rd <= 1'b1;
      @(posedge core_clk);
      reg_req.rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_req.addr <= a;
      reg_req.wdata <= d;
      reg_req.wr <= 1'b1;
      @(posedge core_clk);
      reg_req.wr <= 1'b0;
   endtask
   task automatic kick_tsk;
      @(posedge core_clk);
      kick_req <= 1'b1;
      @(posedge core_clk);
      kick_req <= 1'b0;
   endtask
   task automatic meas(input logic lvl, input int lim, output int cnt);
      cnt = 0;
      #1;
      while (fault === lvl && cnt < lim) begin
         @(posedge core_clk);
         #1 cnt++;
      end
   endtask
   task automatic final_report;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      // Several times the expected run length
      #100000;
      failures++;
      final_report;
   end
   initial begin
      int lw;
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      kick_tsk();
      rd(OFS_UPPER_CAP, 32'h0000_2710);
      rd(OFS_HOLD_CAP, 32'h0000_03E8);
      rd(OFS_FAULT_CNT, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      rd(OFS_STATUS, 32'h0000_001C);
      meas(1'b1, 900, n);
      chk(32'(n > 380 && n < 430), 32'h0000_0001);
      meas(1'b0, 100, n);
      near(n, 20);
      $display("timeout test done");
      repeat (10) @(posedge core_clk);
      kick_tsk();
      meas(1'b1, 12, n);
      chk(32'(n < 12), 32'h0000_0001);
      repeat (4) @(posedge core_clk);
      kick_tsk();
      meas(1'b0, 100, n);
      near(n + 6, 20);
      rd(OFS_FAULT_CNT, 32'h0000_0002);
      wr(OFS_FAULT_CNT, 32'h0000_0000);
      rd(OFS_FAULT_CNT, 32'h0000_0000);
      wr(OFS_UPPER_CAP, 32'h0000_0064);
      wr(OFS_HOLD_CAP, 32'h0000_0006);
      // Let one timeout run out so the next window start is known
      meas(1'b1, 1000, n);
      near(n, 390);
      meas(1'b0, 100, n);
      near(n, 20);
      $display("early kick test done");
      for (int s = 0; s < 3; s++) begin
         lw = (200 >> (3 - s)) * 2;
         @(posedge core_clk);
         straps <= {2'(s), PIN_OPEN, PIN_OPEN};
         repeat (lw - 16) @(posedge core_clk);
         kick_tsk();
         meas(1'b1, 12, n);
         chk(32'(n < 12), 32'h0000_0001);
         meas(1'b0, 100, n);
         repeat (lw + 16) @(posedge core_clk);
         kick_tsk();
         meas(1'b1, 20, n);
         chk(n, 20);
         kick_tsk();
         meas(1'b1, 20, n);
         chk(32'(n < 20), 32'h0000_0001);
         meas(1'b0, 100, n);
      end
      $display("window select test done");
      for (int i = 0; i < 3; i++) begin
         @(posedge core_clk);
         straps <= {2'b00, tps[i], dps[i]};
         meas(1'b1, 1000, n);
         near(n, ups[i]);
         meas(1'b0, 100, n);
         near(n, hds[i]);
      end
      $display("program pin test done");
      @(posedge core_clk);
      straps <= {2'b11, PIN_OPEN, PIN_OPEN};
      repeat (8) begin
         repeat (10) @(posedge core_clk);
         kick_tsk();
      end
      meas(1'b1, 500, n);
      chk(n, 500);
      rd(OFS_STATUS, 32'h0000_031A);
      $display("disable test done");
      final_report;
   end
endmodule

// [bench/wwd_checker.sv]
`timescale 1ns/1ns
module wwd_checker
   import wwd_pkg::*;
#(
   parameter int unsigned UPPER_OPEN_TIME_US = 1000,
   parameter int unsigned HOLD_OPEN_TIME_US = 200,
   parameter int unsigned TICK_DIV = 250
) (
   input wire logic core_clk, // Clock
   input wire logic rst, // Reset
   input wire logic watchdog_kick_in, // Kick pin
   input wire wwd_pkg::wwd_strap_t straps, // Straps
   input wire logic watchdog_fault_in, // Fault wire
   input wire logic watchdog_fault_out_n, // Fault drive value
   input wire logic watchdog_fault_oe, // Fault enable
   input wire wwd_pkg::wwd_req_t reg_req, // Register request
   input wire logic [wwd_pkg::DATA_W-1:0] reg_rdata // Read data
);
   import wwd_pkg::*;
   localparam logic [15:0] HOC = 16'(HOLD_OPEN_TIME_US * TICK_DIV);
   localparam logic [15:0] HMX = 16'(HOLD_OPEN_TIME_US * TICK_DIV + TICK_DIV + 2);
   localparam logic [15:0] LIM = 16'((UPPER_OPEN_TIME_US + HOLD_OPEN_TIME_US + 3) * TICK_DIV + 8);
   // Early limit keeps clear of sync and tick jitter
   localparam logic [15:0] EL = 16'((UPPER_OPEN_TIME_US >> 3) * TICK_DIV - 12);
   logic [15:0] hcnt, quiet, since_rst, since_win;
   logic kick_d, seen_f;
   wwd_strap_t straps_d;
   wire oe = watchdog_fault_oe;
   wire off = straps.window_select_1 && straps.window_select_0 &&
      straps.timeout_program_pin == PIN_OPEN;
   wire base = straps == wwd_strap_t'(6'h00);
   wire dp_open = straps.reset_delay_program_pin == PIN_OPEN;
   wire kfall = kick_d && !watchdog_kick_in;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hcnt <= 16'h0000;
         quiet <= 16'h0000;
         since_rst <= 16'h0000;
         since_win <= 16'h0000;
         kick_d <= 1'b1;
         seen_f <= 1'b0;
         straps_d <= wwd_strap_t'(6'h00);
      end else begin
         hcnt <= oe ? hcnt + 16'h0001 : 16'h0000;
         quiet <= (oe || kfall || straps != straps_d) ? 16'h0000 : quiet + 16'h0001;
         since_rst <= since_rst + {15'h0000, ~&since_rst};
         since_win <= oe ? 16'h0000 : since_win + {15'h0000, ~&since_win};
         kick_d <= watchdog_kick_in;
         seen_f <= seen_f || oe;
         straps_d <= straps;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   property p_out_low; watchdog_fault_out_n == 1'b0; endproperty
   a_out_low: assert property (p_out_low) else $error("fault drive not low");
   property p_off; off |=> !oe; endproperty
   a_off: assert property (p_off) else $error("fault while disabled");
   property p_init; dp_open && since_rst < HOC - 16'h0002 |-> !oe; endproperty
   a_init: assert property (p_init) else $error("fault during power-up hold");
   property p_hold_min; $rose(oe) && !off |-> oe [*8]; endproperty
   a_hold_min: assert property (p_hold_min) else $error("fault hold cut short");
   property p_hold_len;
      $fell(oe) && dp_open && !off && !$past(off) |-> hcnt >= HOC - 16'h0002 && hcnt <= HMX;
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("fault hold length wrong");
   property p_hold_max; oe && dp_open |-> hcnt <= HMX; endproperty
   a_hold_max: assert property (p_hold_max) else $error("fault never released");
   property p_timeout; base |-> quiet <= LIM; endproperty
   a_timeout: assert property (p_timeout) else $error("missing timeout fault");
   property p_early;
      seen_f && base && kfall && since_win > 16'h0004 && since_win < EL |-> ##[2:6] oe;
   endproperty
   a_early: assert property (p_early) else $error("early kick not faulted");
   property p_rdata; !$past(reg_req.rd) |-> reg_rdata == '0; endproperty
   a_rdata: assert property (p_rdata) else $error("read data outside its cycle");
   c_fault: cover property ($rose(oe));
   c_early: cover property (seen_f && base && kfall);
   c_off: cover property (off && kfall);
endmodule
bind wwd_top wwd_checker #(.UPPER_OPEN_TIME_US(UPPER_OPEN_TIME_US),
   .HOLD_OPEN_TIME_US(HOLD_OPEN_TIME_US), .TICK_DIV(TICK_DIV)) i_wwd_checker (.*);

// [bench/wwd_kicker.sv]
`timescale 1ns/1ns
module wwd_kicker (
   input wire logic core_clk, // Clock
   input wire logic rst, // Async reset, high
   input wire logic kick_req, // Bench asks for one kick
   output logic watchdog_kick_in // Kick line
);
   logic [2:0] low_cnt;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         low_cnt <= 3'h0;
      end else if (kick_req) begin
         low_cnt <= 3'h6;
      end else if (low_cnt != 3'h0) begin
         low_cnt <= low_cnt - 3'h1;
      end
   end
   // Always a defined level, also while the watchdog is off
   assign watchdog_kick_in = (low_cnt == 3'h0);
endmodule

// [core/wwd_kick_edge.sv]
`timescale 1ns/1ns
module wwd_kick_edge (
   input wire logic core_clk,  // Clock
   input wire logic rst,       // Async reset, high
   input wire logic kick_in,   // Raw kick pin
   output logic kick_level,    // Synchronised level
   output logic kick_fall      // One-cycle falling edge pulse
);
   logic meta_reg;
   logic prev_reg;

   // Reset high so a kick already low at release gives one falling edge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         meta_reg <= 1'b1;
         kick_level <= 1'b1;
         prev_reg <= 1'b1;
      end else begin
         meta_reg <= kick_in;
         kick_level <= meta_reg;
         prev_reg <= kick_level;
      end
   end

   assign kick_fall = prev_reg & ~kick_level;
endmodule

// [core/wwd_pkg.sv]
package wwd_pkg;

   // Clock and time base
   localparam int unsigned CLK_PERIOD_NS = 4;
   localparam int unsigned TICK_NS = 1000;
   localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned TICK_CNT_W = 16;

   // Widths
   localparam int unsigned CNT_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_UPPER_CAP = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_HOLD_CAP = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_FAULT_CNT = 8'h0C;

   // Reset values, in microseconds where they are times
   localparam logic [CNT_W-1:0] UPPER_CAP_RST = 32'h0000_2710;
   localparam logic [CNT_W-1:0] HOLD_CAP_RST = 32'h0000_03E8;
   localparam logic [DATA_W-1:0] FAULT_CNT_RST = 32'h0000_0000;

   // Preset times in microseconds (defaults of top parameters)
   localparam int unsigned UPPER_OPEN_US = 1000;
   localparam int unsigned UPPER_PULLUP_US = 2000;
   localparam int unsigned HOLD_OPEN_US = 200;
   localparam int unsigned HOLD_PULLUP_US = 100;

   // Lower bound as upper bound shifted right, per window select code
   localparam logic [4:0] SHIFT_SEL00 = 5'h03;
   localparam logic [4:0] SHIFT_SEL01 = 5'h02;
   localparam logic [4:0] SHIFT_SEL10 = 5'h01;
   localparam logic [1:0] SEL_NO_LOWER = 2'h3;

   // Status field positions
   localparam int unsigned ST_FAULT_BIT = 0;
   localparam int unsigned ST_OFF_BIT = 1;
   localparam int unsigned ST_INIT_BIT = 2;
   localparam int unsigned ST_PIN_BIT = 3;
   localparam int unsigned ST_KICK_BIT = 4;
   localparam int unsigned ST_STATE_LSB = 8;

   typedef enum logic [1:0] {
      PIN_OPEN,
      PIN_PULLUP,
      PIN_CAP
   } wwd_pin_t;

   typedef struct packed {
      logic window_select_1;
      logic window_select_0;
      wwd_pin_t timeout_program_pin;
      wwd_pin_t reset_delay_program_pin;
   } wwd_strap_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } wwd_req_t;

   typedef enum logic [1:0] {
      ST_INIT,
      ST_OPEN,
      ST_FAULT,
      ST_OFF
   } wwd_state_t;

endpackage

// [core/wwd_tick.sv]
`timescale 1ns/1ns
module wwd_tick
   import wwd_pkg::*;
#(
   parameter int unsigned DIV = TICK_CYCLES
) (
   input wire logic core_clk, // Clock
   input wire logic rst,      // Async reset, high
   output logic tick          // One-cycle time base pulse
);
   logic [TICK_CNT_W-1:0] div_reg;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_reg <= '0;
         tick <= 1'b0;
      end else if (div_reg == TICK_CNT_W'(DIV - 1)) begin
         div_reg <= '0;
         tick <= 1'b1;
      end else begin
         div_reg <= div_reg + 1'b1;
         tick <= 1'b0;
      end
   end
endmodule

// [core/wwd_top.sv]
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
// What this block does
// - After power-up, kicks are ignored until the fault hold time elapses.
// - Kicks are ignored while the fault output is low.
// - Kicks are ignored entirely while the straps select disabled.
// - On timeout drive fault output low for the hold time, then release.
// - While disabled, the fault output stays high whatever the kick does.
// - Window selects plus timeout pin state choose ratio, timeout, or disable.
// - Timeout pin pulled up or open picks one of the preset timeouts.
// - Delay pin pulled up or open picks one of the preset hold times.
// - With a capacitor on the delay pin, hold time follows the capacitor.
module wwd_top
   import wwd_pkg::*;
#(
   parameter int unsigned UPPER_OPEN_TIME_US = UPPER_OPEN_US,
   parameter int unsigned UPPER_PULLUP_TIME_US = UPPER_PULLUP_US,
   parameter int unsigned HOLD_OPEN_TIME_US = HOLD_OPEN_US,
   parameter int unsigned HOLD_PULLUP_TIME_US = HOLD_PULLUP_US,
   parameter int unsigned TICK_DIV = TICK_CYCLES
) (
   input wire logic core_clk,                  // 250 MHz clock
   input wire logic rst,                       // Async reset, high
   input wire logic watchdog_kick_in,          // Kick from supervised processor
   input wire wwd_pkg::wwd_strap_t straps,     // Window selects and pin states
   input wire logic watchdog_fault_in,         // Level seen on the fault wire
   output logic watchdog_fault_out_n,          // Fault pin drive value, always low
   output logic watchdog_fault_oe,             // High while pulling fault pin low
   input wire wwd_pkg::wwd_req_t reg_req,      // Register strobes, address, data
   output logic [wwd_pkg::DATA_W-1:0] reg_rdata // Read data, cycle after read
);
   import wwd_pkg::*;

   localparam logic [CNT_W-1:0] UPPER_OPEN_CNT = CNT_W'(UPPER_OPEN_TIME_US);
   localparam logic [CNT_W-1:0] UPPER_PULLUP_CNT = CNT_W'(UPPER_PULLUP_TIME_US);
   localparam logic [CNT_W-1:0] HOLD_OPEN_CNT = CNT_W'(HOLD_OPEN_TIME_US);
   localparam logic [CNT_W-1:0] HOLD_PULLUP_CNT = CNT_W'(HOLD_PULLUP_TIME_US);

   logic tick;
   logic kick_level;
   logic kick_fall;
   logic fault_meta_reg;
   logic fault_sync_reg;

   wwd_state_t state_reg;
   wwd_state_t state_next;
   logic [CNT_W-1:0] cnt_reg;
   logic [CNT_W-1:0] cnt_next;

   logic [CNT_W-1:0] upper_cap_reg;
   logic [CNT_W-1:0] hold_cap_reg;
   logic [DATA_W-1:0] fault_cnt_reg;

   logic [CNT_W-1:0] upper_us;
   logic [CNT_W-1:0] lower_us;
   logic [CNT_W-1:0] hold_us;
   logic [1:0] sel;
   logic disabled;
   logic upper_hit;
   logic hold_hit;
   logic fault_entry;

   wwd_tick #(
      .DIV(TICK_DIV)
   ) u_tick (
      .core_clk(core_clk),
      .rst(rst),
      .tick(tick)
   );

   wwd_kick_edge u_kick (
      .core_clk(core_clk),
      .rst(rst),
      .kick_in(watchdog_kick_in),
      .kick_level(kick_level),
      .kick_fall(kick_fall)
   );

   assign sel = {straps.window_select_1, straps.window_select_0};

   // Window decode from straps and program pin states
   always_comb begin
      case (straps.timeout_program_pin)
         PIN_OPEN: upper_us = UPPER_OPEN_CNT;
         PIN_PULLUP: upper_us = UPPER_PULLUP_CNT;
         default: upper_us = upper_cap_reg;
      endcase
      case (sel)
         2'h0: lower_us = upper_us >> SHIFT_SEL00;
         2'h1: lower_us = upper_us >> SHIFT_SEL01;
         2'h2: lower_us = upper_us >> SHIFT_SEL10;
         default: lower_us = '0;
      endcase
      case (straps.reset_delay_program_pin)
         PIN_OPEN: hold_us = HOLD_OPEN_CNT;
         PIN_PULLUP: hold_us = HOLD_PULLUP_CNT;
         default: hold_us = hold_cap_reg;
      endcase
   end

   // Disable only with selects both high and the timeout pin open
   assign disabled = (sel == SEL_NO_LOWER) && (straps.timeout_program_pin == PIN_OPEN);
   assign upper_hit = (cnt_reg >= upper_us);
   assign hold_hit = (cnt_reg >= hold_us);

   // Window sequencing; counter runs in microsecond ticks
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      case (state_reg)
         ST_INIT: begin
            // Kicks disregarded until the power-up hold has run out
            if (hold_hit) begin
               state_next = disabled ? ST_OFF : ST_OPEN;
               cnt_next = '0;
            end else if (tick) begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         ST_OPEN: begin
            if (disabled) begin
               state_next = ST_OFF;
               cnt_next = '0;
            end else if (kick_fall) begin
               if (cnt_reg < lower_us) begin
                  state_next = ST_FAULT;
               end
               cnt_next = '0;
            end else if (upper_hit) begin
               state_next = ST_FAULT;
               cnt_next = '0;
            end else if (tick) begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         ST_FAULT: begin
            // Kick edges are not looked at here
            if (disabled) begin
               state_next = ST_OFF;
               cnt_next = '0;
            end else if (hold_hit) begin
               state_next = ST_OPEN;
               cnt_next = '0;
            end else if (tick) begin
               cnt_next = cnt_reg + 1'b1;
            end
         end
         default: begin
            // Leaving disable starts a fresh window
            if (!disabled) begin
               state_next = ST_OPEN;
               cnt_next = '0;
            end
         end
      endcase
   end

   assign fault_entry = (state_next == ST_FAULT) && (state_reg != ST_FAULT);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_INIT;
         cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
      end
   end

   // Open-drain fault pin: only ever pulls low
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         watchdog_fault_out_n <= 1'b0;
         watchdog_fault_oe <= 1'b0;
      end else begin
         watchdog_fault_out_n <= 1'b0;
         watchdog_fault_oe <= (state_next == ST_FAULT);
      end
   end

   // Fault wire readback for status
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fault_meta_reg <= 1'b1;
         fault_sync_reg <= 1'b1;
      end else begin
         fault_meta_reg <= watchdog_fault_in;
         fault_sync_reg <= fault_meta_reg;
      end
   end

   // Capacitor-equivalent times written by software
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         upper_cap_reg <= UPPER_CAP_RST;
         hold_cap_reg <= HOLD_CAP_RST;
      end else if (reg_req.wr) begin
         if (reg_req.addr == OFS_UPPER_CAP) begin
            upper_cap_reg <= reg_req.wdata;
         end else if (reg_req.addr == OFS_HOLD_CAP) begin
            hold_cap_reg <= reg_req.wdata;
         end
      end
   end

   // New fault wins over a clear in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         fault_cnt_reg <= FAULT_CNT_RST;
      end else if (reg_req.wr && (reg_req.addr == OFS_FAULT_CNT)) begin
         fault_cnt_reg <= fault_entry ? DATA_W'(1) : FAULT_CNT_RST;
      end else if (fault_entry && (fault_cnt_reg != '1)) begin
         fault_cnt_reg <= fault_cnt_reg + 1'b1;
      end
   end

   // Read data live for exactly one cycle; unmapped reads give zero
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (!reg_req.rd) begin
         reg_rdata <= '0;
      end else if (reg_req.addr == OFS_UPPER_CAP) begin
         reg_rdata <= upper_cap_reg;
      end else if (reg_req.addr == OFS_HOLD_CAP) begin
         reg_rdata <= hold_cap_reg;
      end else if (reg_req.addr == OFS_STATUS) begin
         reg_rdata <= '0;
         reg_rdata[ST_FAULT_BIT] <= (state_reg == ST_FAULT);
         reg_rdata[ST_OFF_BIT] <= (state_reg == ST_OFF);
         reg_rdata[ST_INIT_BIT] <= (state_reg == ST_INIT);
         reg_rdata[ST_PIN_BIT] <= fault_sync_reg;
         reg_rdata[ST_KICK_BIT] <= kick_level;
         reg_rdata[ST_STATE_LSB +: 2] <= state_reg;
      end else if (reg_req.addr == OFS_FAULT_CNT) begin
         reg_rdata <= fault_cnt_reg;
      end else begin
         reg_rdata <= '0;
      end
   end

endmodule
